// [logic/ocx_defines.svh]
// Constants for the completion scoreboard and register crossbar.
`ifndef OCX_DEFINES_SVH
`define OCX_DEFINES_SVH
`define OCX_NREG 64
`define OCX_RW 6
`define OCX_DW 64
`define OCX_NEU 4
`define OCX_EUW 2
`define OCX_NSRC 3
`define OCX_NWB 2
`define OCX_TAGW 7
`define OCX_RANKW 3
`define OCX_IMM_SLOT 1
`define OCX_REG_ZERO 6'h00
`define OCX_GO_ONE 4'h1
`define OCX_MASK_B 64'h00000000000000FF
`define OCX_MASK_H 64'h000000000000FFFF
`define OCX_MASK_W 64'h00000000FFFFFFFF
`define OCX_MASK_D 64'hFFFFFFFFFFFFFFFF
`endif

// [logic/ocx_pkg.sv]
// Types shared by the scoreboard and crossbar core.
`include "ocx_defines.svh"
package ocx_pkg;
  typedef logic [`OCX_RW-1:0] ocx_reg_t;
  typedef logic [`OCX_DW-1:0] ocx_data_t;
  typedef logic [`OCX_TAGW-1:0] ocx_tag_t;
  typedef enum logic [1:0] {
    OCX_IMM_B = 2'h0,
    OCX_IMM_H = 2'h1,
    OCX_IMM_W = 2'h2,
    OCX_IMM_D = 2'h3
  } ocx_immw_e;
  // One decoded instruction as the decoder hands it over.
  typedef struct packed {
    logic [`OCX_NSRC-1:0] src_use;
    ocx_reg_t [`OCX_NSRC-1:0] src;
    logic dst_use;
    ocx_reg_t dst;
    logic [`OCX_EUW-1:0] unit;
    logic imm_use;
    ocx_immw_e immw;
    ocx_data_t imm;
  } ocx_instr_s;
  // Operand bundle broadcast to the units; go selects one unit.
  typedef struct packed {
    logic [`OCX_NEU-1:0] go;
    ocx_data_t [`OCX_NSRC-1:0] opnd;
    logic dst_use;
    ocx_reg_t dst;
    ocx_tag_t tag;
  } ocx_op_s;
  // Result returned by a unit, tag copied from its operand bundle.
  typedef struct packed {
    logic dst_use;
    ocx_reg_t dst;
    ocx_data_t data;
    ocx_tag_t tag;
  } ocx_res_s;
  // One register write bus.
  typedef struct packed {
    logic we;
    ocx_reg_t addr;
    ocx_data_t data;
  } ocx_wr_s;
endpackage

// [logic/ocx_core.sv]
// Issue scoreboard, register crossbar and write-back arbiter.
`timescale 1ns/1ps
`include "ocx_defines.svh"
module ocx_core
  import ocx_pkg::*;
(
  input wire logic core_clk, // Core clock, 125 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic dec_valid, // Decoder offers an instruction.
  input wire ocx_instr_s dec_instr, // Offered instruction.
  output logic dec_ready, // Decode slot can take one.
  output ocx_reg_t [`OCX_NSRC-1:0] rf_rd_addr, // Read addresses.
  input wire ocx_data_t [`OCX_NSRC-1:0] rf_rd_data, // Read data.
  output ocx_op_s eu_op, // Operands to the units.
  input wire logic [`OCX_NEU-1:0] eu_res_valid, // Unit result ready.
  input wire ocx_res_s [`OCX_NEU-1:0] eu_res, // Unit results.
  output logic [`OCX_NEU-1:0] eu_res_ready, // Result slot free.
  output ocx_wr_s [`OCX_NWB-1:0] rf_wr, // Register write buses.
  output logic [`OCX_NWB-1:0] wb_zero // Bus result is zero.
);

  // The busy flags live only here; no port reads or loads them.
  logic [`OCX_NREG-1:0] busy;
  logic [`OCX_NREG-1:0] next_busy;
  logic hold_full;
  logic next_hold_full;
  ocx_instr_s hold;
  ocx_instr_s next_hold;
  logic next_dec_ready;
  ocx_tag_t seq;
  ocx_tag_t next_seq;
  ocx_reg_t [`OCX_NSRC-1:0] next_rf_rd_addr;
  logic r_valid;
  logic next_r_valid;
  ocx_instr_s r_ins;
  ocx_instr_s next_r_ins;
  ocx_tag_t r_tag;
  ocx_tag_t next_r_tag;
  ocx_op_s next_eu_op;
  logic [`OCX_NEU-1:0] slot_v;
  logic [`OCX_NEU-1:0] next_slot_v;
  ocx_res_s [`OCX_NEU-1:0] slot;
  ocx_res_s [`OCX_NEU-1:0] next_slot;
  logic [`OCX_NEU-1:0] next_eu_res_ready;
  ocx_wr_s [`OCX_NWB-1:0] next_rf_wr;
  logic [`OCX_NWB-1:0] next_wb_zero;
  logic [`OCX_NEU-1:0] grant;
  logic [`OCX_NREG-1:0] clr_vec;
  logic [`OCX_NREG-1:0] set_vec;
  logic stall;
  logic issue;
  ocx_tag_t [`OCX_NEU-1:0] age;
  logic [`OCX_NEU-1:0][`OCX_RANKW-1:0] rank;

  // Age of each waiting result; the counter is wider than the number
  // of results that can be in flight, so wrap never inverts order.
  // Rank counts valid slots that are older, ties broken by index.
  genvar gi;
  generate
    for (gi = 0; gi < `OCX_NEU; gi++) begin : g_rank
      assign age[gi] = seq - slot[gi].tag;
      always_comb begin
        rank[gi] = '0;
        for (int j = 0; j < `OCX_NEU; j++) begin
          if (j != gi && slot_v[j] && (age[j] > age[gi] ||
              (age[j] == age[gi] && j < gi))) begin
            rank[gi] = rank[gi] + `OCX_RANKW'(1);
          end
        end
      end
      assign grant[gi] = slot_v[gi] &&
                         rank[gi] < `OCX_RANKW'(`OCX_NWB);
    end
  endgenerate

  // Scoreboard and decode hold. A register counts as free when its
  // flag is clear or its result is granted a write bus right now; the
  // operand is then taken from that bus in the crossbar stage.
  always_comb begin
    clr_vec = '0;
    set_vec = '0;
    for (int i = 0; i < `OCX_NEU; i++) begin
      if (grant[i] && slot[i].dst_use) begin
        clr_vec[slot[i].dst] = 1'b1;
      end
    end
    stall = 1'b0;
    for (int k = 0; k < `OCX_NSRC; k++) begin
      if (hold.src_use[k] && hold.src[k] != `OCX_REG_ZERO &&
          busy[hold.src[k]] && !clr_vec[hold.src[k]]) begin
        stall = 1'b1;
      end
    end
    // The destination gets the same test; no other WAW logic.
    if (hold.dst_use && hold.dst != `OCX_REG_ZERO &&
        busy[hold.dst] && !clr_vec[hold.dst]) begin
      stall = 1'b1;
    end
    // Only the held instruction is checked, so order is kept.
    issue = hold_full && !stall;
    if (issue && hold.dst_use && hold.dst != `OCX_REG_ZERO) begin
      set_vec[hold.dst] = 1'b1;
    end
    // Set wins over a clear of the same register in one cycle.
    next_busy = (busy & ~clr_vec) | set_vec;
    next_busy[`OCX_REG_ZERO] = 1'b0;
    next_hold_full = hold_full && !issue;
    next_hold = hold;
    if (dec_valid && dec_ready) begin
      next_hold_full = 1'b1;
      next_hold = dec_instr;
    end
    // Ready is registered, so the slot refills every other cycle.
    next_dec_ready = !next_hold_full;
    next_seq = seq + {{(`OCX_TAGW-1){1'b0}}, issue};
    next_rf_rd_addr = rf_rd_addr;
    if (issue) begin
      next_rf_rd_addr = hold.src;
    end
    next_r_valid = issue;
    next_r_ins = issue ? hold : r_ins;
    next_r_tag = issue ? seq : r_tag;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= '0;
      hold_full <= 1'b0;
      hold <= '0;
      dec_ready <= 1'b0;
      seq <= '0;
      rf_rd_addr <= '0;
      r_valid <= 1'b0;
      r_ins <= '0;
      r_tag <= '0;
    end else begin
      busy <= next_busy;
      hold_full <= next_hold_full;
      hold <= next_hold;
      dec_ready <= next_dec_ready;
      seq <= next_seq;
      rf_rd_addr <= next_rf_rd_addr;
      r_valid <= next_r_valid;
      r_ins <= next_r_ins;
      r_tag <= next_r_tag;
    end
  end

  // Crossbar stage: register file data, zero register, bypass from the
  // write buses and the formatted immediate meet here, in the same cycle
  // that the read addresses are driven.
  always_comb begin
    next_eu_op = eu_op;
    next_eu_op.go = '0;
    if (r_valid) begin
      next_eu_op.go = `OCX_GO_ONE << r_ins.unit;
      next_eu_op.dst_use = r_ins.dst_use;
      next_eu_op.dst = r_ins.dst;
      next_eu_op.tag = r_tag;
      for (int k = 0; k < `OCX_NSRC; k++) begin
        next_eu_op.opnd[k] = rf_rd_data[k];
        for (int b = 0; b < `OCX_NWB; b++) begin
          if (rf_wr[b].we && rf_wr[b].addr == r_ins.src[k]) begin
            next_eu_op.opnd[k] = rf_wr[b].data;
          end
        end
        if (r_ins.src[k] == `OCX_REG_ZERO || !r_ins.src_use[k]) begin
          next_eu_op.opnd[k] = '0;
        end
      end
      if (r_ins.imm_use) begin
        unique case (r_ins.immw)
          OCX_IMM_B: next_eu_op.opnd[`OCX_IMM_SLOT] =
            r_ins.imm & `OCX_MASK_B;
          OCX_IMM_H: next_eu_op.opnd[`OCX_IMM_SLOT] =
            r_ins.imm & `OCX_MASK_H;
          OCX_IMM_W: next_eu_op.opnd[`OCX_IMM_SLOT] =
            r_ins.imm & `OCX_MASK_W;
          OCX_IMM_D: next_eu_op.opnd[`OCX_IMM_SLOT] =
            r_ins.imm & `OCX_MASK_D;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      eu_op <= '0;
    end else begin
      eu_op <= next_eu_op;
    end
  end

  // Write-back: each unit owns one result slot, so a slow unit never
  // holds up the others. Up to two oldest results leave per cycle.
  always_comb begin
    next_slot_v = slot_v & ~grant;
    next_slot = slot;
    for (int i = 0; i < `OCX_NEU; i++) begin
      if (eu_res_valid[i] && eu_res_ready[i]) begin
        next_slot_v[i] = 1'b1;
        next_slot[i] = eu_res[i];
      end
    end
    next_eu_res_ready = ~next_slot_v;
    next_rf_wr = '0;
    next_wb_zero = '0;
    for (int i = 0; i < `OCX_NEU; i++) begin
      for (int b = 0; b < `OCX_NWB; b++) begin
        if (grant[i] && rank[i] == `OCX_RANKW'(b)) begin
          // Both buses load in one cycle, so up to two granted
          // results are written together; any others wait.
          next_rf_wr[b].we = slot[i].dst_use &&
                             slot[i].dst != `OCX_REG_ZERO;
          next_rf_wr[b].addr = slot[i].dst;
          next_rf_wr[b].data = slot[i].data;
          next_wb_zero[b] = slot[i].data == '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slot_v <= '0;
      slot <= '0;
      eu_res_ready <= '0;
      rf_wr <= '0;
      wb_zero <= '0;
    end else begin
      slot_v <= next_slot_v;
      slot <= next_slot;
      eu_res_ready <= next_eu_res_ready;
      rf_wr <= next_rf_wr;
      wb_zero <= next_wb_zero;
    end
  end

endmodule

// [tb/ocx_core_assertions.sv]
// Port checker for the scoreboard and crossbar core.
`timescale 1ns/1ps
`include "ocx_defines.svh"
module ocx_chk
  import ocx_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic resetn, // Reset, active low.
  input wire logic dec_valid, // Decoder offer.
  input wire logic dec_ready, // Decode slot free.
  input wire ocx_op_s eu_op, // Operands to units.
  input wire logic [`OCX_NEU-1:0] eu_res_valid, // Result offered.
  input wire logic [`OCX_NEU-1:0] eu_res_ready, // Result slot free.
  input wire ocx_wr_s [`OCX_NWB-1:0] rf_wr, // Write buses.
  input wire logic [`OCX_NWB-1:0] wb_zero // Zero test ports.
);
  logic pend;
  logic next_pend;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // An offer was taken and its operand bundle is still owed.
  always_comb begin
    next_pend = pend;
    if (dec_valid && dec_ready) begin
      next_pend = 1'b1;
    end else if (dec_ready) begin
      next_pend = 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend <= 1'b0;
    end else begin
      pend <= next_pend;
    end
  end
  sequence s_take;
    dec_valid && dec_ready;
  endsequence
  sequence s_slot_back;
    dec_ready && pend;
  endsequence
  a_take_drops: assert property (s_take |=> !dec_ready)
    else $error("decode slot stayed free after a take");
  a_one_unit: assert property ($onehot0(eu_op.go))
    else $error("more than one unit started");
  a_go_latency: assert property (s_slot_back |=> |eu_op.go)
    else $error("operands late after issue");
  a_reg0_never: assert property (!(rf_wr[0].we && rf_wr[0].addr == 6'h00)
    && !(rf_wr[1].we && rf_wr[1].addr == 6'h00))
    else $error("write to register zero");
  a_zero_flag: assert property (rf_wr[0].we |-> wb_zero[0] ==
    (rf_wr[0].data == 64'h0000000000000000))
    else $error("zero test port wrong");
  a_bus_order: assert property (rf_wr[1].we |-> rf_wr[0].we)
    else $error("second bus used alone");
  a_two_dst: assert property (rf_wr[0].we && rf_wr[1].we
    |-> rf_wr[0].addr != rf_wr[1].addr)
    else $error("same register written twice");
  a_slot_taken: assert property (eu_res_valid[0] && eu_res_ready[0]
    |=> !eu_res_ready[0])
    else $error("result slot not held");
endmodule
bind ocx_core ocx_chk i_ocx_chk (.core_clk, .resetn, .dec_valid,
  .dec_ready, .eu_op, .eu_res_valid, .eu_res_ready, .rf_wr, .wb_zero);

// [tb/ocx_far.sv]
// Register file and execution unit model facing the core.
`timescale 1ns/1ps
`include "ocx_defines.svh"
module ocx_far
  import ocx_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire ocx_reg_t [`OCX_NSRC-1:0] rf_rd_addr, // Read addresses.
  output ocx_data_t [`OCX_NSRC-1:0] rf_rd_data, // Read data.
  input wire ocx_wr_s [`OCX_NWB-1:0] rf_wr, // Write buses.
  input wire ocx_op_s eu_op, // Unit operands.
  output logic [`OCX_NEU-1:0] eu_res_valid, // Result offered.
  output ocx_res_s [`OCX_NEU-1:0] eu_res, // Unit results.
  input wire logic [`OCX_NEU-1:0] eu_res_ready // Slot free.
);
  ocx_data_t regs [`OCX_NREG];
  int cnt [`OCX_NEU];
  initial begin
    foreach (regs[k]) regs[k] = '0;
    foreach (cnt[k]) cnt[k] = 0;
    eu_res_valid = '0;
    eu_res = '0;
  end
  // Three reads answered in the same cycle.
  always_comb begin
    for (int k = 0; k < `OCX_NSRC; k++) begin
      rf_rd_data[k] = regs[rf_rd_addr[k]];
    end
  end
  // Unit i takes i+1 cycles, so slow and fast units overlap; result is a^b.
  always @(posedge core_clk) begin
    for (int b = 0; b < `OCX_NWB; b++) begin
      if (rf_wr[b].we) regs[rf_wr[b].addr] <= rf_wr[b].data;
    end
    for (int i = 0; i < `OCX_NEU; i++) begin
      if (eu_res_valid[i] && eu_res_ready[i]) eu_res_valid[i] <= 1'b0;
      if (eu_op.go[i]) begin
        cnt[i] <= i + 1;
        eu_res[i] <= {eu_op.dst_use, eu_op.dst,
          eu_op.opnd[0] ^ eu_op.opnd[1], eu_op.tag};
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
        if (cnt[i] == 1) eu_res_valid[i] <= 1'b1;
      end
    end
  end
endmodule

// [tb/tb_ooo_completion_scoreboard_xbar.sv]
// Self-checking bench for the scoreboard and crossbar core.
`timescale 1ns/1ps
`include "ocx_defines.svh"
module tb_ooo_completion_scoreboard_xbar;
  import ocx_pkg::*;
  logic core_clk, resetn, dec_valid, dec_ready;
  ocx_instr_s dec_instr;
  ocx_reg_t [`OCX_NSRC-1:0] rf_rd_addr;
  ocx_data_t [`OCX_NSRC-1:0] rf_rd_data;
  ocx_op_s eu_op;
  logic [`OCX_NEU-1:0] eu_res_valid, eu_res_ready;
  ocx_res_s [`OCX_NEU-1:0] eu_res;
  ocx_wr_s [`OCX_NWB-1:0] rf_wr;
  logic [`OCX_NWB-1:0] wb_zero;
  int fails = 0;
  int checks_done = 0;
  localparam ocx_data_t IMM = 64'hF0E1D2C3B4A59687;
  ocx_core i_ocx_core (.core_clk, .resetn, .dec_valid, .dec_instr,
    .dec_ready, .rf_rd_addr, .rf_rd_data, .eu_op, .eu_res_valid,
    .eu_res, .eu_res_ready, .rf_wr, .wb_zero);
  ocx_far i_ocx_far (.core_clk, .rf_rd_addr, .rf_rd_data, .rf_wr,
    .eu_op, .eu_res_valid, .eu_res, .eu_res_ready);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic stop_test;
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input ocx_reg_t r, input ocx_data_t exp);
    checks_done++;
    if (i_ocx_far.regs[r] !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, i_ocx_far.regs[r], exp);
    end
  endtask
  function automatic ocx_instr_s mk(ocx_reg_t a, ocx_reg_t b, ocx_reg_t d,
    logic [1:0] u, logic iu, ocx_immw_e w);
    mk = '0;
    mk.src_use = {1'b0, !iu, 1'b1};
    mk.src[0] = a;
    mk.src[1] = b;
    mk.dst_use = 1'b1;
    mk.dst = d;
    mk.unit = u;
    mk.imm_use = iu;
    mk.immw = w;
    mk.imm = IMM;
  endfunction
  // Offer held until the slot takes it; the watchdog covers a hang.
  task automatic send(input ocx_instr_s in);
    @(negedge core_clk);
    dec_valid = 1'b1;
    dec_instr = in;
    while (dec_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    dec_valid = 1'b0;
  endtask
  // Every immediate width issued back to back, register zero as source.
  task automatic t_imm;
    ocx_data_t m [4] = '{`OCX_MASK_B, `OCX_MASK_H, `OCX_MASK_W, `OCX_MASK_D};
    for (int w = 0; w < 4; w++) send(mk(0, 0, w + 1, 0, 1, ocx_immw_e'(w)));
    repeat (12) @(negedge core_clk);
    for (int w = 0; w < 4; w++) chk(w + 1, IMM & m[w]);
  endtask
  // Slow result, independent work behind it, then a stalled dependant.
  task automatic t_dep;
    int seen;
    seen = 0;
    send(mk(0, 0, 10, 3, 1, OCX_IMM_H));
    send(mk(0, 0, 12, 1, 1, OCX_IMM_B));
    send(mk(10, 1, 11, 0, 0, OCX_IMM_B));
    send(mk(11, 0, 11, 2, 1, OCX_IMM_B));
    send(mk(1, 1, 13, 0, 0, OCX_IMM_B));
    // The zero result must raise the zero-test port of its bus once.
    for (int n = 0; n < 20; n++) begin
      @(negedge core_clk);
      for (int b = 0; b < `OCX_NWB; b++) begin
        if (rf_wr[b].we && rf_wr[b].addr == 6'h0D) begin
          seen++;
          checks_done++;
          if (wb_zero[b] !== 1'b1) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, wb_zero[b], 1'b1);
          end
        end
      end
    end
    checks_done++;
    if (seen != 1) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, seen, 1);
    end
    chk(10, 64'h9687);
    chk(12, 64'h87);
    chk(13, 64'h0);
    chk(11, 64'h9687 ^ 64'h87 ^ 64'h87);
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    dec_valid = 1'b0;
    dec_instr = '0;
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    t_imm();
    t_dep();
    stop_test();
  end
endmodule
